// file: dv/rfdt_tb.sv
// Self-checking bench for the RF driver timing register block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rfdt_pkg::*;

    // RF period in clock cycles; pulse width shrinks as speed rises
    localparam int P = 50;
    logic clk, srst;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic driver_enable, rf_carrier_pin, nonoverlap_pin;
    logic [2:0] drv_speed, peer_detect_threshold;
    logic search_busy, min_nonoverlap_select, resam_active;
    logic [6:0] resam_resistance_code;
    logic [3:0] collision_avoid_threshold;
    logic [DATA_W-1:0] exp_r[$];
    logic [1:0] exp_rr[$];
    logic [1:0] exp_b[$];
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 28230;
    int ph = 0;
    int w = 0;
    int wn;
    logic [7:0] d;

    rfdt_top #(.CNT_W(8)) DUT (
        .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .driver_enable, .rf_carrier_pin,
        .nonoverlap_pin, .drv_speed, .search_busy, .min_nonoverlap_select,
        .resam_resistance_code, .resam_active, .peer_detect_threshold,
        .collision_avoid_threshold
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Ceiling well above the longest expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_sim;
        end
    end

    // Carrier and non-overlap pins stand low while the driver is off
    always @(posedge clk)
    begin
        wn = (ph == 0) ? 2 * (5 - int'(drv_speed)) : w;
        w <= wn;
        ph <= (driver_enable && ph < P - 1) ? ph + 1 : 0;
        rf_carrier_pin <= driver_enable && ph < P / 2;
        nonoverlap_pin <= driver_enable &&
            (ph < wn || (ph >= P / 2 && ph < P / 2 + wn));
    end

    always @(posedge clk)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            chk("rdata", s_axi_rdata, exp_r.pop_front());
            chk("rresp", s_axi_rresp, exp_rr.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", s_axi_bresp, exp_b.pop_front());
    end

    task automatic wr(logic [11:0] a, logic [7:0] v, logic [3:0] st,
                      logic [1:0] resp);
        bit da, dw;
        da = 0;
        dw = 0;
        exp_b.push_back(resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(da && dw))
        begin
            @(posedge clk);
            if (!da && s_axi_awready === 1'b1)
            begin
                da = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!dw && s_axi_wready === 1'b1)
            begin
                dw = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] v, logic [1:0] resp);
        exp_r.push_back(v);
        exp_rr.push_back(resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    function automatic int exp_step(int tgt);
        for (int s = 0; s < 4; s++)
            if (P >= tgt * 4 * (5 - s))
                return s;
        return 4;
    endfunction

    task automatic auto_run(int tgt);
        int n;
        n = 0;
        wr(ADDR_TIMING, {tgt[3:0], 4'h4}, 4'h1, RESP_OKAY);
        driver_enable <= 1'b1;
        repeat (3) @(posedge clk);
        chk("busy", search_busy, 1);
        while (search_busy === 1'b1 && n < 20 * P)
        begin
            @(posedge clk);
            n++;
        end
        chk("search_len", n <= 10 * P + 40, 1);
        repeat (2) @(posedge clk);
        chk("auto_speed", drv_speed, exp_step(tgt));
        driver_enable <= 1'b0;
        @(posedge clk);
    endtask

    initial
    begin
        srst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, driver_enable} = '0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rst_speed", drv_speed, SPD_FAST);
        chk("rst_peer", peer_detect_threshold, 3'h3);
        chk("rst_coll", collision_avoid_threshold, 4'h3);
        chk("rst_minnov", min_nonoverlap_select, 0);
        chk("rst_code", resam_resistance_code, 0);
        rd(ADDR_TIMING, 32'h0000007C, RESP_OKAY);
        rd(ADDR_THRESH, 32'h00000033, RESP_OKAY);
        rd(ADDR_RESAM, 32'h00000000, RESP_OKAY);
        rd(12'h100, 32'h00000000, RESP_DECERR);
        wr(12'h100, 8'hFF, 4'h1, RESP_DECERR);
        // Auto search with three targets, then an aborted one
        auto_run(0);
        auto_run(5);
        auto_run(15);
        rd(ADDR_STATUS, 32'h00000044, RESP_OKAY);
        wr(ADDR_TIMING, 8'hF4, 4'h1, RESP_OKAY);
        driver_enable <= 1'b1;
        repeat (3 * P) @(posedge clk);
        // Retarget while running restarts from the slowest step
        wr(ADDR_TIMING, 8'h04, 4'h1, RESP_OKAY);
        rd(ADDR_STATUS, 32'h00000008, RESP_OKAY);
        driver_enable <= 1'b0;
        repeat (3) @(posedge clk);
        chk("abort", search_busy, 0);
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_TIMING, {4'h7, 1'b1, i[2:0]}, 4'h1, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk("man_speed", drv_speed, i[2] ? 4 : (i == 3) ? 3 :
                (i == 0) ? 0 : 1);
            rd(ADDR_TIMING, {28'h7, 1'b1, i[2:0]}, RESP_OKAY);
        end
        for (int i = 0; i < 6; i++)
        begin
            d = 8'($random(seed));
            wr(ADDR_THRESH, d, 4'h1, RESP_OKAY);
            wr(ADDR_THRESH, ~d, 4'h0, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk("peer", peer_detect_threshold, d[6:4]);
            chk("coll", collision_avoid_threshold, d[3:0]);
            rd(ADDR_THRESH, {24'h0, 1'b0, d[6:0]}, RESP_OKAY);
            d = 8'($random(seed));
            wr(ADDR_RESAM_EN, 8'h00, 4'h1, RESP_OKAY);
            wr(ADDR_RESAM, d, 4'h1, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk("minnov", min_nonoverlap_select, d[7]);
            chk("code_off", resam_resistance_code, 0);
            chk("active_off", resam_active, 0);
            wr(ADDR_RESAM_EN, 8'h01, 4'h1, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk("code_on", resam_resistance_code, d[6:0]);
            chk("active_on", resam_active, 1);
            rd(ADDR_RESAM_EN, 32'h00000001, RESP_OKAY);
            rd(ADDR_RESAM, {24'h0, d}, RESP_OKAY);
        end
        repeat (4) @(posedge clk);
        end_sim;
    end
endmodule

// file: rtl/rfdt_pkg.sv
// Shared constants for the RF driver timing and configuration block
package rfdt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register indices, two spaces; byte address is the space base plus four times the index
    localparam logic [7:0] IDX_TIMING = 8'h29;
    localparam logic [7:0] IDX_THRESH = 8'h2A;
    localparam logic [7:0] IDX_RESAM = 8'h2A;
    localparam logic [7:0] IDX_RESAM_EN = 8'h2B;
    localparam logic [7:0] IDX_STATUS = 8'h2C;
    localparam logic [11:0] SPACE_A_BASE = 12'h000;
    localparam logic [11:0] SPACE_B_BASE = 12'h400;
    localparam logic [11:0] ADDR_THRESH = SPACE_A_BASE + {2'h0, IDX_THRESH, 2'h0};
    localparam logic [11:0] ADDR_TIMING = SPACE_B_BASE + {2'h0, IDX_TIMING, 2'h0};
    localparam logic [11:0] ADDR_RESAM = SPACE_B_BASE + {2'h0, IDX_RESAM, 2'h0};
    localparam logic [11:0] ADDR_RESAM_EN =
        SPACE_B_BASE + {2'h0, IDX_RESAM_EN, 2'h0};
    localparam logic [11:0] ADDR_STATUS = SPACE_B_BASE + {2'h0, IDX_STATUS, 2'h0};

    // Reset values
    localparam logic [7:0] RST_TIMING = 8'h7C;
    localparam logic [7:0] RST_THRESH = 8'h33;
    localparam logic [7:0] RST_RESAM = 8'h00;
    localparam logic [7:0] RST_RESAM_EN = 8'h00;

    // Field positions
    localparam int TGT_HI = 7;
    localparam int TGT_LO = 4;
    localparam int MAN_BIT = 3;
    localparam int MCODE_HI = 2;
    localparam int PEER_HI = 6;
    localparam int PEER_LO = 4;
    localparam int COLL_HI = 3;
    localparam int MINNOV_BIT = 7;
    localparam int RCODE_HI = 6;
    localparam int RESAM_EN_BIT = 0;

    // Driver transient speeds, slowest first
    localparam logic [2:0] SPD_SLOW = 3'h0;
    localparam logic [2:0] SPD_MED_SLOW = 3'h1;
    localparam logic [2:0] SPD_MED_FAST = 3'h3;
    localparam logic [2:0] SPD_FAST = 3'h4;
    localparam logic [2:0] SPD_LAST = 3'h4;
    localparam logic [3:0] MAX_PERIODS = 4'hA;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_MEASURE} rfdt_state_e;
endpackage

// file: rtl/rfdt_ratio_meter.sv
// Measures one RF period against summed non-overlap time
module rfdt_ratio_meter #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rf_level,
    input wire logic nonov_level,
    input wire logic [3:0] target,
    output logic meas_valid,
    output logic below_target
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    logic rf_d;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] nonov_cnt;
    logic [CNT_W+3:0] scaled_nonov;
    logic rf_rise;

    // Narrower counters saturate inside one RF period
    if (CNT_W < 4)
    begin : g_cnt_w_check
        $error("rfdt_ratio_meter: CNT_W must be at least 4");
    end

    assign rf_rise = rf_level & ~rf_d;
    // Multiply instead of divide; widths hold the full product
    assign scaled_nonov = {4'h0, nonov_cnt} * {{CNT_W{1'b0}}, target};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rf_d <= 1'b0;
            period_cnt <= '0;
            nonov_cnt <= '0;
            meas_valid <= 1'b0;
            below_target <= 1'b0;
        end
        else
        begin
            rf_d <= rf_level;
            meas_valid <= rf_rise && (period_cnt != '0);
            if (rf_rise)
            begin
                // Ratio below target: period < target * non-overlap
                below_target <= {4'h0, period_cnt} < scaled_nonov;
                period_cnt <= {{(CNT_W-1){1'b0}}, 1'b1};
                nonov_cnt <= {{(CNT_W-1){1'b0}}, nonov_level};
            end
            else
            begin
                if (period_cnt != CNT_MAX)
                    period_cnt <= period_cnt + 1'b1;
                // Both edges' non-overlap intervals add up here
                if (nonov_level && nonov_cnt != CNT_MAX)
                    nonov_cnt <= nonov_cnt + 1'b1;
            end
        end
    end

    a_ratio_compare: assert property (@(posedge clk) disable iff (srst)
        rf_rise && period_cnt != '0 |=>
        meas_valid && below_target ==
        ($past({4'h0, period_cnt}) < $past(scaled_nonov)))
        else $error("ratio comparison wrong");
endmodule

// file: rtl/rfdt_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module rfdt_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    if (WIDTH < 1)
    begin : g_width_check
        $error("rfdt_sync: WIDTH must be at least 1");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta;
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    meta <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    meta <= async_in[i];
                    sync_out[i] <= meta;
                end
            end
        end
    endgenerate
endmodule

// file: rtl/rfdt_top.sv
// RF driver timing, field threshold and resistive AM register block
// Overview of operation
// - Auto search steps slow to fast until target
// - Five speed steps, at most ten RF periods
// - Ratio is RF period over total non-overlap
// - Bits 7:4 hold ratio target, reset 0111
// - Bit 3 picks auto or manual, reset 1
// - Manual code maps slow to fast, reset 100
// - Threshold register holds peer and collision fields
// - Bit 7 selects minimum non-overlap, reset 0
// - Bits 6:0 give modulated resistance code, reset 0
// - Resistance code applies only when enable set
module rfdt_top
#(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [rfdt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rfdt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rfdt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rfdt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic driver_enable,
    input wire logic rf_carrier_pin,
    input wire logic nonoverlap_pin,
    output logic [2:0] drv_speed,
    output logic search_busy,
    output logic min_nonoverlap_select,
    output logic [6:0] resam_resistance_code,
    output logic resam_active,
    output logic [2:0] peer_detect_threshold,
    output logic [3:0] collision_avoid_threshold
);
    import rfdt_pkg::*;

    logic [7:0] timing_reg;
    logic [7:0] thresh_reg;
    logic [7:0] resam_reg;
    logic [7:0] resam_en_reg;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic do_write;
    logic wr_hit;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [1:0] pins_sync;
    logic meas_valid;
    logic below_target;
    rfdt_state_e state;
    logic [2:0] auto_step;
    logic [3:0] period_cnt;
    logic en_d;
    logic search_start;
    logic [2:0] next_speed;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = aw_addr == ADDR_TIMING || aw_addr == ADDR_THRESH ||
        aw_addr == ADDR_RESAM || aw_addr == ADDR_RESAM_EN ||
        aw_addr == ADDR_STATUS;

    // Address and data accepted in either order
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && !do_write;
            s_axi_wready <= !w_held && !s_axi_wready && !do_write;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Status is read only; writes to it are accepted and dropped
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            timing_reg <= RST_TIMING;
            thresh_reg <= RST_THRESH;
            resam_reg <= RST_RESAM;
            resam_en_reg <= RST_RESAM_EN;
        end
        else if (do_write && w_lane0)
        begin
            if (aw_addr == ADDR_TIMING)
                timing_reg <= w_byte;
            if (aw_addr == ADDR_THRESH)
                thresh_reg <= {1'b0, w_byte[6:0]};
            if (aw_addr == ADDR_RESAM)
                resam_reg <= w_byte;
            if (aw_addr == ADDR_RESAM_EN)
                resam_en_reg <= {7'h00, w_byte[RESAM_EN_BIT]};
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            ADDR_TIMING: rd_byte = timing_reg;
            ADDR_THRESH: rd_byte = thresh_reg;
            ADDR_RESAM: rd_byte = resam_reg;
            ADDR_RESAM_EN: rd_byte = resam_en_reg;
            ADDR_STATUS: rd_byte = {1'b0, drv_speed, search_busy, auto_step};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    rfdt_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({nonoverlap_pin, rf_carrier_pin}),
        .sync_out(pins_sync)
    );

    rfdt_ratio_meter #(
        .CNT_W(CNT_W)
    ) u_meter (
        .clk(clk),
        .srst(srst),
        .rf_level(pins_sync[0]),
        .nonov_level(pins_sync[1]),
        .target(timing_reg[TGT_HI:TGT_LO]),
        .meas_valid(meas_valid),
        .below_target(below_target)
    );

    // Retarget also restarts the search while the driver runs
    assign search_start = driver_enable &&
        (!en_d || (do_write && w_lane0 && aw_addr == ADDR_TIMING));

    // First period of each step is discarded: the driver settles
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= S_IDLE;
            auto_step <= SPD_SLOW;
            period_cnt <= 4'h0;
            search_busy <= 1'b0;
            en_d <= 1'b0;
        end
        else
        begin
            en_d <= driver_enable;
            if (!driver_enable)
            begin
                state <= S_IDLE;
                search_busy <= 1'b0;
            end
            else if (search_start)
            begin
                state <= S_SETTLE;
                auto_step <= SPD_SLOW;
                period_cnt <= 4'h0;
                search_busy <= 1'b1;
            end
            else if (meas_valid)
            begin
                unique case (state)
                    S_IDLE: state <= S_IDLE;
                    S_SETTLE:
                    begin
                        state <= S_MEASURE;
                        period_cnt <= period_cnt + 4'h1;
                    end
                    S_MEASURE:
                    begin
                        period_cnt <= period_cnt + 4'h1;
                        if (below_target && auto_step != SPD_LAST)
                        begin
                            auto_step <= auto_step + 3'h1;
                            state <= S_SETTLE;
                        end
                        else
                        begin
                            state <= S_IDLE;
                            search_busy <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    always_comb
    begin
        next_speed = auto_step;
        if (timing_reg[MAN_BIT])
        begin
            casez (timing_reg[MCODE_HI:0])
                3'b000: next_speed = SPD_SLOW;
                3'b001: next_speed = SPD_MED_SLOW;
                3'b011: next_speed = SPD_MED_FAST;
                3'b1??: next_speed = SPD_FAST;
                default: next_speed = SPD_MED_SLOW;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            drv_speed <= SPD_FAST;
            min_nonoverlap_select <= 1'b0;
            resam_resistance_code <= 7'h00;
            resam_active <= 1'b0;
            peer_detect_threshold <= RST_THRESH[PEER_HI:PEER_LO];
            collision_avoid_threshold <= RST_THRESH[COLL_HI:0];
        end
        else
        begin
            drv_speed <= next_speed;
            min_nonoverlap_select <= resam_reg[MINNOV_BIT];
            resam_active <= resam_en_reg[RESAM_EN_BIT];
            resam_resistance_code <= resam_en_reg[RESAM_EN_BIT] ?
                resam_reg[RCODE_HI:0] : 7'h00;
            peer_detect_threshold <= thresh_reg[PEER_HI:PEER_LO];
            collision_avoid_threshold <= thresh_reg[COLL_HI:0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_manual_fast;
        timing_reg[MAN_BIT] && timing_reg[MCODE_HI];
    endsequence
    sequence s_step_up;
        meas_valid && state == S_MEASURE && below_target &&
        auto_step != SPD_LAST && driver_enable && !search_start;
    endsequence

    a_reset_values: assert property ($past(srst) |->
        timing_reg == 8'h7C && thresh_reg == 8'h33 && resam_reg == 8'h00)
        else $error("reset values wrong");
    a_search_begin: assert property (search_start |=>
        auto_step == SPD_SLOW && state == S_SETTLE && search_busy)
        else $error("search did not start slowest");
    a_step_faster: assert property (s_step_up |=>
        auto_step == $past(auto_step) + 3'h1 && state == S_SETTLE)
        else $error("no step to faster transient");
    a_step_limit: assert property (auto_step <= 3'h4)
        else $error("more than five steps");
    a_period_bound: assert property (search_busy |->
        period_cnt <= MAX_PERIODS)
        else $error("search longer than ten periods");
    a_manual_fast: assert property (s_manual_fast |=>
        drv_speed == 3'h4)
        else $error("manual fast not applied");
    a_auto_apply: assert property (!timing_reg[MAN_BIT] |=>
        drv_speed == $past(auto_step))
        else $error("auto timing not applied");
    a_min_nonov: assert property (##1 min_nonoverlap_select ==
        $past(resam_reg[7]))
        else $error("non-overlap select mismatch");
    a_resam_gate: assert property (!resam_en_reg[0] ##1 1 |->
        resam_resistance_code == 7'h00 && !resam_active)
        else $error("code applied while disabled");
    a_resam_code: assert property (resam_en_reg[0] ##1 resam_en_reg[0]
        |-> resam_resistance_code == $past(resam_reg[6:0]))
        else $error("resistance code mismatch");
    a_thresh_fields: assert property (##1 peer_detect_threshold ==
        $past(thresh_reg[6:4]) && thresh_reg[7] == 1'b0)
        else $error("threshold fields wrong");
    a_read_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule
